// *** hw/chgst_status_regs.sv ***
`timescale 1ns/10ps
module chgst_status_regs #(
    parameter int DEGLITCH_CYCLES = chgst_pkg::CHGST_LOWBAT_DEGLITCH_CYC,
    parameter logic [6:0] SLAVE_ADDR = 7'h09,
    parameter bit HAS_GPIN = 1'b0
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // serial management port (open drain data)
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_b,
    // control bits from the configuration registers
    input wire logic high_impedance_mode,
    input wire logic charge_override,
    input wire logic boost_override,
    input wire logic temp_profile_disable,
    input wire logic thermistor_sense_disable,
    input wire logic cold_limit_setting,
    input wire logic [1:0] hot_limit_setting,
    // pins
    input wire logic charge_enable_pin,
    input wire logic boost_request_pin_b,
    input wire logic gpin_level,
    input wire logic interrupt_drive_state,
    // analog comparators and loops
    input wire logic vbat_below_good,
    input wire logic input_undervoltage_live,
    input wire logic input_overvoltage_live,
    input wire logic thermal_reg_active,
    input wire logic input_current_loop_active,
    input wire logic input_voltage_loop_active,
    input wire logic thermistor_batt_sensed,
    input wire logic signed [7:0] battery_temp_c,
    input wire logic [15:0] boost_sense_mv,
    input wire logic [15:0] boost_target_mv,
    input wire logic [15:0] battery_sense_mv,
    input wire logic [15:0] termination_voltage_setting,
    // charger core state
    input wire logic [3:0] charge_state_raw,
    // status to the power stage
    output chgst_pkg::chgst_mode_t operation_mode,
    output logic converter_run
);
    import chgst_pkg::*;

    // ****************************************
    // top-level mode
    // ****************************************
    chgst_mode_t mode_q;
    chgst_mode_t mode_d;
    logic run_q;
    logic temp_stop;

    initial
    begin
        if (DEGLITCH_CYCLES < 1)
            $error("deglitch count must be at least one");
    end

    // charging wins when both requests stand; 11 is never produced
    always_comb
    begin
        mode_d = CHGST_MODE_HIZ;
        if (!high_impedance_mode)
        begin
            if (charge_enable_pin || charge_override)
                mode_d = CHGST_MODE_CHARGE;
            else if (!boost_request_pin_b || boost_override)
                mode_d = CHGST_MODE_BOOST;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            mode_q <= CHGST_MODE_HIZ;
        else
            mode_q <= mode_d;
    end

    // ****************************************
    // low battery deglitch
    // ****************************************
    chgst_filt_if lowbat_if ();
    assign lowbat_if.raw = vbat_below_good;

    chgst_deglitch #(
        .CYCLES(DEGLITCH_CYCLES)
    ) u_lowbat (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .f(lowbat_if)
    );

    // ****************************************
    // power good with hysteresis
    // ****************************************
    logic pg_q;
    logic [31:0] pg_sense;
    logic [31:0] pg_target;

    always_comb
    begin
        pg_sense = 32'(boost_sense_mv) * CHGST_PG_FULL_PCT;
        pg_target = 32'(boost_target_mv);
        if (mode_q == CHGST_MODE_CHARGE)
        begin
            pg_sense = 32'(battery_sense_mv) * CHGST_PG_FULL_PCT;
            pg_target = 32'(termination_voltage_setting);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            pg_q <= 1'b0;
        else if (mode_q == CHGST_MODE_HIZ)
            pg_q <= 1'b0;
        else if (pg_sense < pg_target * CHGST_PG_CLR_PCT)
            pg_q <= 1'b0;
        else if (pg_sense > pg_target * CHGST_PG_SET_PCT)
            pg_q <= 1'b1;
    end

    // ****************************************
    // status words
    // ****************************************
    logic [7:0] gen_q;
    logic [7:0] gen_d;
    logic [7:0] chg_q;
    logic [7:0] chg_d;
    logic [7:0] tmp_q;
    logic [7:0] tmp_d;
    logic is_chg;
    logic is_boost;
    logic guard_zone;
    logic profile_zone;
    logic signed [7:0] hot_lim;
    logic signed [7:0] cold_lim;

    assign is_chg = (mode_q == CHGST_MODE_CHARGE);
    assign is_boost = (mode_q == CHGST_MODE_BOOST);
    assign guard_zone = is_boost || (is_chg && temp_profile_disable);
    assign profile_zone = is_chg && !temp_profile_disable;
    assign cold_lim = cold_limit_setting ? CHGST_T_M10C : CHGST_T_0C;
    assign hot_lim = (hot_limit_setting == 2'b00) ? CHGST_T_55C :
                     (hot_limit_setting == 2'b01) ? CHGST_T_60C : CHGST_T_65C;

    always_comb
    begin
        gen_d = CHGST_RST_REG;
        gen_d[CHGST_GEN_LOWBAT] = (mode_q != CHGST_MODE_HIZ) && lowbat_if.filtered;
        gen_d[CHGST_GEN_IRQ] = interrupt_drive_state;
        gen_d[CHGST_GEN_BOOSTPIN] = boost_request_pin_b;
        gen_d[CHGST_GEN_UVLO] = is_chg && input_undervoltage_live;
        gen_d[CHGST_GEN_OV] = is_chg && input_overvoltage_live;
        gen_d[CHGST_GEN_GPIN] = HAS_GPIN && gpin_level;
        gen_d[1:0] = mode_q;
    end

    always_comb
    begin
        chg_d = CHGST_RST_REG;
        chg_d[CHGST_CHG_ENPIN] = charge_enable_pin;
        chg_d[CHGST_CHG_THERM] = (is_chg || is_boost) && thermal_reg_active;
        chg_d[CHGST_CHG_ILIM] = is_chg && input_current_loop_active;
        chg_d[CHGST_CHG_VLIM] = is_chg && input_voltage_loop_active;
        chg_d[3:0] = charge_state_raw;
        if (!is_chg)
            chg_d[3:0] = CHGST_CS_RESET;
        // undefined codes fall back to reset rather than leak out
        if (charge_state_raw >= CHGST_CS_INVALID_LO || charge_state_raw == CHGST_CS_UNUSED)
            chg_d[3:0] = CHGST_CS_RESET;
    end

    always_comb
    begin
        tmp_d = CHGST_RST_REG;
        tmp_d[CHGST_TMP_PG] = pg_q;
        tmp_d[CHGST_TMP_BATT] = !thermistor_sense_disable && thermistor_batt_sensed;
        tmp_d[CHGST_TMP_COLDDIS] = guard_zone && (battery_temp_c < cold_lim);
        tmp_d[CHGST_TMP_HOTDIS] = guard_zone && (battery_temp_c > hot_lim);
        tmp_d[CHGST_TMP_COLD] = profile_zone && (battery_temp_c < CHGST_T_0C);
        tmp_d[CHGST_TMP_COOL] = profile_zone && (battery_temp_c >= CHGST_T_0C)
                                && (battery_temp_c < CHGST_T_10C);
        tmp_d[CHGST_TMP_WARM] = profile_zone && (battery_temp_c > CHGST_T_45C)
                                && (battery_temp_c <= CHGST_T_60C);
        tmp_d[CHGST_TMP_HOT] = profile_zone && (battery_temp_c > CHGST_T_60C);
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            gen_q <= CHGST_RST_REG;
            chg_q <= CHGST_RST_REG;
            tmp_q <= CHGST_RST_REG;
        end
        else
        begin
            gen_q <= gen_d;
            chg_q <= chg_d;
            tmp_q <= tmp_d;
        end
    end

    // the converter stops on any hard temperature zone, mode kept for status
    assign temp_stop = tmp_d[CHGST_TMP_COLDDIS] || tmp_d[CHGST_TMP_HOTDIS]
                       || tmp_d[CHGST_TMP_COLD] || tmp_d[CHGST_TMP_HOT];

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            run_q <= 1'b0;
        else
            run_q <= (mode_q != CHGST_MODE_HIZ) && !temp_stop;
    end

    // ****************************************
    // serial management slave
    // ****************************************
    chgst_sp_t sp_q;
    logic scl_q;
    logic sda_q;
    logic [3:0] bit_q;
    logic [7:0] sh_q;
    logic [7:0] ptr_q;
    logic rw_q;
    logic nack_q;
    logic oe_b_q;
    logic [7:0] rd_byte;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    assign scl_rise = scl_in && !scl_q;
    assign scl_fall = !scl_in && scl_q;
    assign start_det = scl_in && scl_q && sda_q && !sda_in;
    assign stop_det = scl_in && scl_q && !sda_q && sda_in;

    // unmapped offsets read as zero; the map is read-only
    always_comb
    begin
        case (ptr_q)
            CHGST_OFS_GENERAL: rd_byte = gen_q;
            CHGST_OFS_CHARGE: rd_byte = chg_q;
            CHGST_OFS_TEMP: rd_byte = tmp_q;
            default: rd_byte = CHGST_RST_REG;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end
        else
        begin
            scl_q <= scl_in;
            sda_q <= sda_in;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sp_q <= CHGST_SP_IDLE;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            ptr_q <= 8'h00;
            rw_q <= 1'b0;
            nack_q <= 1'b0;
            oe_b_q <= 1'b1;
        end
        else if (start_det)
        begin
            sp_q <= CHGST_SP_ADDR;
            bit_q <= 4'h0;
            oe_b_q <= 1'b1;
        end
        else if (stop_det)
        begin
            sp_q <= CHGST_SP_IDLE;
            oe_b_q <= 1'b1;
        end
        else if (scl_rise)
        begin
            case (sp_q)
                CHGST_SP_ADDR, CHGST_SP_PTR, CHGST_SP_WDATA:
                begin
                    sh_q <= {sh_q[6:0], sda_in};
                    bit_q <= bit_q + 4'h1;
                end
                CHGST_SP_RDATA_ACK: nack_q <= sda_in;
                default: ;
            endcase
        end
        else if (scl_fall)
        begin
            case (sp_q)
                CHGST_SP_ADDR:
                    if (bit_q == 4'h8)
                    begin
                        if (sh_q[7:1] == SLAVE_ADDR)
                        begin
                            sp_q <= CHGST_SP_ADDR_ACK;
                            rw_q <= sh_q[0];
                            oe_b_q <= 1'b0;
                        end
                        else
                            sp_q <= CHGST_SP_IDLE;
                    end
                CHGST_SP_ADDR_ACK:
                begin
                    bit_q <= 4'h0;
                    if (rw_q)
                    begin
                        sp_q <= CHGST_SP_RDATA;
                        sh_q <= {rd_byte[6:0], 1'b0};
                        oe_b_q <= rd_byte[7];
                        bit_q <= 4'h1;
                    end
                    else
                    begin
                        sp_q <= CHGST_SP_PTR;
                        oe_b_q <= 1'b1;
                    end
                end
                CHGST_SP_PTR, CHGST_SP_WDATA:
                    if (bit_q == 4'h8)
                    begin
                        if (sp_q == CHGST_SP_PTR)
                        begin
                            ptr_q <= sh_q;
                            sp_q <= CHGST_SP_PTR_ACK;
                        end
                        else
                            sp_q <= CHGST_SP_WDATA_ACK;
                        oe_b_q <= 1'b0;
                    end
                CHGST_SP_PTR_ACK, CHGST_SP_WDATA_ACK:
                begin
                    // data bytes are acknowledged and dropped: nothing here is writable
                    sp_q <= CHGST_SP_WDATA;
                    bit_q <= 4'h0;
                    oe_b_q <= 1'b1;
                end
                CHGST_SP_RDATA:
                    if (bit_q == 4'h8)
                    begin
                        // step ahead now so the next byte is ready at the ack fall
                        sp_q <= CHGST_SP_RDATA_ACK;
                        ptr_q <= ptr_q + 8'h01;
                        oe_b_q <= 1'b1;
                    end
                    else
                    begin
                        oe_b_q <= sh_q[7];
                        sh_q <= {sh_q[6:0], 1'b0};
                        bit_q <= bit_q + 4'h1;
                    end
                CHGST_SP_RDATA_ACK:
                    if (nack_q)
                        sp_q <= CHGST_SP_IDLE;
                    else
                    begin
                        sp_q <= CHGST_SP_RDATA;
                        sh_q <= {rd_byte[6:0], 1'b0};
                        oe_b_q <= rd_byte[7];
                        bit_q <= 4'h1;
                    end
                default: sp_q <= CHGST_SP_IDLE;
            endcase
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe_b = oe_b_q;
    assign operation_mode = mode_q;
    assign converter_run = run_q;
endmodule

// *** hw/chgst_pkg.sv ***
//
// Function
// - low-battery flag set below threshold, zero in high-impedance
// - low-battery flag deglitched 16 ms both edges
// - bit 6 shows own interrupt drive, not pin
// - bit 5 mirrors boost request pin level
// - live undervoltage/overvoltage bits, charger mode only
// - bit 2 mirrors input pin, else zero
// - mode field 00/01/10, never 11
// - charger bit 7 mirrors charge-enable pin level
// - thermal regulation bit in charger and boost
// - input current/voltage loop bits, charger only
// - charge state codes reported as defined
// - charge state forced 0000 when not charging
// - charge codes 1100-1111 never reported
// - power good clears below 90%, sets above 92%
// - battery present from thermistor, zero when disabled
// - cold disable below 0 or -10 C
// - hot disable above 55/60/65 C
// - profile cold zone below 0 C stops charging
// - profile cool zone 0 to 10 C
// - profile warm zone 45 to 60 C
// - profile hot zone above 60 C stops charging
// - high-impedance bit blocks pins and overrides
package chgst_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] CHGST_OFS_GENERAL = 8'h02;
    localparam logic [7:0] CHGST_OFS_CHARGE = 8'h03;
    localparam logic [7:0] CHGST_OFS_TEMP = 8'h04;
    localparam logic [7:0] CHGST_RST_REG = 8'h00;
    localparam int CHGST_GEN_LOWBAT = 7;
    localparam int CHGST_GEN_IRQ = 6;
    localparam int CHGST_GEN_BOOSTPIN = 5;
    localparam int CHGST_GEN_UVLO = 4;
    localparam int CHGST_GEN_OV = 3;
    localparam int CHGST_GEN_GPIN = 2;
    localparam int CHGST_CHG_ENPIN = 7;
    localparam int CHGST_CHG_THERM = 6;
    localparam int CHGST_CHG_ILIM = 5;
    localparam int CHGST_CHG_VLIM = 4;
    localparam int CHGST_TMP_PG = 7;
    localparam int CHGST_TMP_BATT = 6;
    localparam int CHGST_TMP_COLDDIS = 5;
    localparam int CHGST_TMP_HOTDIS = 4;
    localparam int CHGST_TMP_COLD = 3;
    localparam int CHGST_TMP_COOL = 2;
    localparam int CHGST_TMP_WARM = 1;
    localparam int CHGST_TMP_HOT = 0;
    // ****************************************
    // modes and charge codes
    // ****************************************
    typedef enum logic [1:0] {
        CHGST_MODE_HIZ = 2'b00,
        CHGST_MODE_CHARGE = 2'b01,
        CHGST_MODE_BOOST = 2'b10
    } chgst_mode_t;
    localparam logic [3:0] CHGST_CS_RESET = 4'h0;
    localparam logic [3:0] CHGST_CS_UNUSED = 4'hB;
    localparam logic [3:0] CHGST_CS_INVALID_LO = 4'hC;
    // ****************************************
    // serial port states
    // ****************************************
    typedef enum logic [3:0] {
        CHGST_SP_IDLE = 4'b0000,
        CHGST_SP_ADDR = 4'b0001,
        CHGST_SP_ADDR_ACK = 4'b0010,
        CHGST_SP_PTR = 4'b0011,
        CHGST_SP_PTR_ACK = 4'b0100,
        CHGST_SP_WDATA = 4'b0101,
        CHGST_SP_WDATA_ACK = 4'b0110,
        CHGST_SP_RDATA = 4'b0111,
        CHGST_SP_RDATA_ACK = 4'b1000
    } chgst_sp_t;
    // ****************************************
    // thresholds (degrees C in two's complement, power good in percent)
    // ****************************************
    localparam logic signed [7:0] CHGST_T_0C = 8'sh00;
    localparam logic signed [7:0] CHGST_T_M10C = 8'shF6;
    localparam logic signed [7:0] CHGST_T_10C = 8'sh0A;
    localparam logic signed [7:0] CHGST_T_45C = 8'sh2D;
    localparam logic signed [7:0] CHGST_T_55C = 8'sh37;
    localparam logic signed [7:0] CHGST_T_60C = 8'sh3C;
    localparam logic signed [7:0] CHGST_T_65C = 8'sh41;
    localparam logic [31:0] CHGST_PG_CLR_PCT = 32'h0000_005A;
    localparam logic [31:0] CHGST_PG_SET_PCT = 32'h0000_005C;
    localparam logic [31:0] CHGST_PG_FULL_PCT = 32'h0000_0064;
    // ****************************************
    // timing
    // ****************************************
    localparam int CHGST_CLK_HZ = 25000000;
    localparam int CHGST_LOWBAT_DEGLITCH_MS = 16;
    localparam int CHGST_LOWBAT_DEGLITCH_CYC =
        CHGST_LOWBAT_DEGLITCH_MS * (CHGST_CLK_HZ / 1000);
endpackage

// *** hw/chgst_filt_if.sv ***
`timescale 1ns/10ps
interface chgst_filt_if;
    logic raw;
    logic filtered;
    modport filt
    (
        input raw,
        output filtered
    );
    modport user
    (
        output raw,
        input filtered
    );
endinterface

// *** hw/chgst_deglitch.sv ***
`timescale 1ns/10ps
module chgst_deglitch #(
    parameter int CYCLES = 16
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // level in, filtered level out
    chgst_filt_if.filt f
);
    import chgst_pkg::*;
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
    logic [CW-1:0] cnt_q;
    logic out_q;

    initial
    begin
        if (CYCLES < 1)
            $error("deglitch needs at least one cycle");
    end

    // a change must hold for the whole window; any bounce restarts it
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt_q <= '0;
            out_q <= 1'b0;
        end
        else if (f.raw == out_q)
            cnt_q <= '0;
        else if (cnt_q == LAST)
        begin
            cnt_q <= '0;
            out_q <= f.raw;
        end
        else
            cnt_q <= cnt_q + CW'(1);
    end

    assign f.filtered = out_q;
endmodule

// *** dv/chgst_status_regs_monitor.sv ***
`timescale 1ns/10ps
module chgst_status_regs_monitor (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // controls and pins
    input wire logic high_impedance_mode,
    input wire logic charge_override,
    input wire logic boost_override,
    input wire logic temp_profile_disable,
    input wire logic charge_enable_pin,
    input wire logic boost_request_pin_b,
    input wire logic signed [7:0] battery_temp_c,
    // watched outputs
    input chgst_pkg::chgst_mode_t operation_mode,
    input wire logic converter_run
);
    import chgst_pkg::*;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);
    logic hz, cq, bq, cm, bx;
    logic [1:0] md;
    assign md = operation_mode;
    assign hz = high_impedance_mode;
    assign cq = charge_enable_pin | charge_override;
    assign bq = !boost_request_pin_b | boost_override;
    assign cm = md == CHGST_MODE_CHARGE && !temp_profile_disable;
    assign bx = md == CHGST_MODE_BOOST && (battery_temp_c < CHGST_T_M10C || battery_temp_c > CHGST_T_65C);
    // causes are held two or three samples since mode and run are registered
    a_mode_never_11: assert property (md != 2'b11)
        else $error("mode field reads 11");
    a_hiz_blocks_all: assert property (hz [*2] |-> md == CHGST_MODE_HIZ)
        else $error("mode left high impedance");
    a_charge_wins: assert property ((!hz && cq) [*2] |-> md == CHGST_MODE_CHARGE)
        else $error("charge request not in charger mode");
    a_boost_chosen: assert property ((!hz && !cq && bq) [*2] |-> md == CHGST_MODE_BOOST)
        else $error("boost request not in boost mode");
    a_idle_no_req: assert property ((!hz && !cq && !bq) [*2] |-> md == CHGST_MODE_HIZ)
        else $error("mode active without request");
    a_run_needs_mode: assert property (converter_run |-> $past(md) != CHGST_MODE_HIZ)
        else $error("converter runs in high impedance");
    a_cold_zone_stop: assert property ((cm && battery_temp_c < CHGST_T_0C) [*3] |-> !converter_run)
        else $error("charging below cold zone");
    a_hot_zone_stop: assert property ((cm && battery_temp_c > CHGST_T_60C) [*3] |-> !converter_run)
        else $error("charging above hot zone");
    a_boost_temp_stop: assert property (bx [*3] |-> !converter_run)
        else $error("boost runs outside temperature limits");
endmodule

// *** dv/chgst_i2c_host.sv ***
`timescale 1ns/10ps
module chgst_i2c_host (
    // clock and resolved data wire
    input wire logic sys_clk,
    input wire logic sda,
    // open drain drive, 1 releases to the pull-up
    output logic scl,
    output logic sda_rel,
    // one pulse per received byte or address ack
    output logic [7:0] res,
    output logic res_v
);
    initial
    begin
        scl = 1'b1;
        sda_rel = 1'b1;
        res = 8'h00;
        res_v = 1'b0;
    end
    task automatic q();
        repeat (3) @(negedge sys_clk);
    endtask
    task automatic emit(input logic [7:0] v);
        res = v;
        res_v = 1'b1;
        @(negedge sys_clk);
        res_v = 1'b0;
    endtask
    // v=0 start or repeated start, v=1 stop; scl dropped first so no false stop
    task automatic cond(input logic v);
        scl = 1'b0;
        q();
        sda_rel = !v;
        q();
        scl = 1'b1;
        q();
        sda_rel = v;
        q();
    endtask
    task automatic bitx(input logic b, output logic s);
        scl = 1'b0;
        q();
        sda_rel = b;
        q();
        scl = 1'b1;
        q();
        s = sda;
        q();
    endtask
    task automatic byt(input logic [7:0] w, input logic ak, output logic [7:0] d, output logic a);
        for (int i = 7; i >= 0; i--)
            bitx(w[i], d[i]);
        bitx(ak, a);
    endtask
    task automatic xfer(input logic [6:0] a, input logic [7:0] p, input int n, input bit wr);
        logic [7:0] d;
        logic k;
        cond(1'b0);
        byt({a, 1'b0}, 1'b1, d, k);
        emit({7'h00, k});
        if (!k)
        begin
            byt(p, 1'b1, d, k);
            if (wr)
                byt(8'hFF, 1'b1, d, k);
            else
            begin
                cond(1'b0);
                byt({a, 1'b1}, 1'b1, d, k);
                for (int i = 0; i < n; i++)
                begin
                    byt(8'hFF, i == n - 1, d, k);
                    emit(d);
                end
            end
        end
        cond(1'b1);
    endtask
endmodule

// *** dv/chgst_status_regs_tb.sv ***
`timescale 1ns/10ps
`define CHK(g, e) \
    begin \
        n_checks++; \
        if ((g) !== (e)) \
        begin \
            mismatches++; \
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); \
        end \
    end
module chgst_status_regs_tb;
    import chgst_pkg::*;
    localparam int DEG = 2000;
    localparam logic [6:0] ADDR = 7'h09;
    logic sys_clk = 1'b0, rst_b = 1'b0, lb = 1'b0;
    logic scl_in, sda_in, sda_rel, sda_out, sda_oe_b, converter_run, res_v;
    logic high_impedance_mode = 1'b1, charge_override = 1'b0, boost_override = 1'b0;
    logic temp_profile_disable = 1'b0, thermistor_sense_disable = 1'b0, cold_limit_setting = 1'b0;
    logic charge_enable_pin = 1'b0, boost_request_pin_b = 1'b0, gpin_level = 1'b0;
    logic interrupt_drive_state = 1'b0, vbat_below_good = 1'b0, input_undervoltage_live = 1'b0;
    logic input_overvoltage_live = 1'b0, thermal_reg_active = 1'b0, thermistor_batt_sensed = 1'b0;
    logic input_current_loop_active = 1'b0, input_voltage_loop_active = 1'b0;
    logic [1:0] hot_limit_setting = 2'b00;
    logic [3:0] charge_state_raw = 4'h0;
    logic signed [7:0] battery_temp_c = 8'sh19;
    logic [15:0] boost_sense_mv = 16'h2134, battery_sense_mv = 16'h2134;
    logic [15:0] boost_target_mv = 16'h2710, termination_voltage_setting = 16'h2710;
    logic [7:0] res, ex;
    logic [7:0] exp_q[$];
    logic [31:0] r;
    logic signed [7:0] tv [15] = '{8'shF5, 8'shF6, 8'shFF, 8'sh00, 8'sh09, 8'sh0A, 8'sh2D,
        8'sh2E, 8'sh37, 8'sh38, 8'sh3C, 8'sh3D, 8'sh41, 8'sh42, 8'sh19};
    chgst_mode_t operation_mode;
    integer seed = 76596;
    int mismatches = 0, n_checks = 0;
    always #20 sys_clk = ~sys_clk;
    assign sda_in = sda_rel & (sda_oe_b | sda_out);
    chgst_status_regs #(.DEGLITCH_CYCLES(DEG), .SLAVE_ADDR(ADDR)) i_dut (.*);
    chgst_i2c_host h (.sys_clk(sys_clk), .sda(sda_in), .scl(scl_in), .sda_rel(sda_rel),
        .res(res), .res_v(res_v));
    function automatic logic [23:0] model();
        logic [1:0] m;
        logic ch, oz, jz;
        logic signed [7:0] t, cl, hl;
        logic [7:0] g, c, p;
        t = battery_temp_c;
        m = high_impedance_mode ? 2'b00 : (charge_enable_pin | charge_override) ? 2'b01 :
            (!boost_request_pin_b | boost_override) ? 2'b10 : 2'b00;
        ch = m == 2'b01;
        oz = m == 2'b10 || (ch && temp_profile_disable);
        jz = ch & !temp_profile_disable;
        cl = cold_limit_setting ? CHGST_T_M10C : CHGST_T_0C;
        hl = hot_limit_setting == 2'b00 ? CHGST_T_55C : hot_limit_setting == 2'b01 ? CHGST_T_60C
            : CHGST_T_65C;
        g = {lb & (|m), interrupt_drive_state, boost_request_pin_b, input_undervoltage_live & ch,
            input_overvoltage_live & ch, 1'b0, m};
        c = {charge_enable_pin, thermal_reg_active & (|m), input_current_loop_active & ch,
            input_voltage_loop_active & ch, (ch && charge_state_raw < 4'hB) ? charge_state_raw : 4'h0};
        p = {(|m) && (ch ? battery_sense_mv : boost_sense_mv) > 16'h23F0,
            thermistor_batt_sensed & !thermistor_sense_disable, oz && t < cl, oz && t > hl,
            jz && t < CHGST_T_0C, jz && t >= CHGST_T_0C && t < CHGST_T_10C,
            jz && t > CHGST_T_45C && t <= CHGST_T_60C, jz && t > CHGST_T_60C};
        return {g, c, p};
    endfunction
    // address ack, unmapped 0x01, the three status bytes by auto-increment, unmapped 0x05
    task automatic rd();
        logic [23:0] e;
        repeat (4) @(negedge sys_clk);
        e = model();
        exp_q.push_back(8'h00);
        exp_q.push_back(8'h00);
        exp_q.push_back(e[23:16]);
        exp_q.push_back(e[15:8]);
        exp_q.push_back(e[7:0]);
        exp_q.push_back(8'h00);
        h.xfer(ADDR, 8'h01, 5, 1'b0);
    endtask
    task automatic stop_test();
        if (exp_q.size() != 0)
            mismatches++;
        if (mismatches == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge res_v)
    begin
        ex = exp_q.pop_front();
        `CHK(res, ex)
    end
    initial
    begin
        repeat (100000) @(posedge sys_clk);
        mismatches++;
        stop_test();
    end
    initial
    begin
        repeat (5) @(negedge sys_clk);
        rst_b = 1'b1;
        rd();
        // a write is acked but leaves the read-only bytes alone; foreign address gets no ack
        exp_q.push_back(8'h00);
        h.xfer(ADDR, CHGST_OFS_CHARGE, 0, 1'b1);
        exp_q.push_back(8'h01);
        h.xfer(ADDR ^ 7'h01, CHGST_OFS_GENERAL, 1, 1'b0);
        rd();
        // groups of 15: idle or boost, boost, charge with profile, charge without
        for (int i = 0; i < 60; i++)
        begin
            @(negedge sys_clk);
            r = $random(seed);
            high_impedance_mode = i < 15 && r[1:0] == 2'b00;
            charge_enable_pin = i >= 30 && r[2];
            charge_override = i >= 30 && !r[2];
            temp_profile_disable = i < 30 ? r[3] : i >= 45;
            boost_override = i >= 15 && i < 30 && r[4];
            boost_request_pin_b = i < 15 ? r[5] : (i < 30 ? r[4] & r[5] : r[5]);
            {thermistor_sense_disable, cold_limit_setting, hot_limit_setting} = r[9:6];
            {gpin_level, interrupt_drive_state, input_undervoltage_live} = r[12:10];
            {input_overvoltage_live, thermal_reg_active, thermistor_batt_sensed} = r[15:13];
            {input_current_loop_active, input_voltage_loop_active} = r[17:16];
            battery_sense_mv = r[18] ? 16'h251C : 16'h2134;
            boost_sense_mv = r[19] ? 16'h251C : 16'h2134;
            charge_state_raw = 4'(i);
            battery_temp_c = tv[i % 15];
            rd();
        end
        // a read finishes well inside the filter time, so it sees the old flag
        vbat_below_good = 1'b1;
        rd();
        repeat (DEG) @(negedge sys_clk);
        lb = 1'b1;
        rd();
        vbat_below_good = 1'b0;
        rd();
        repeat (DEG) @(negedge sys_clk);
        lb = 1'b0;
        rd();
        vbat_below_good = 1'b1;
        repeat (DEG) @(negedge sys_clk);
        lb = 1'b1;
        high_impedance_mode = 1'b1;
        rd();
        stop_test();
    end
endmodule
bind chgst_status_regs chgst_status_regs_monitor i_mon (.*);
